//--- rtl/vfd_mux_pkg.sv
// Constants, register map and timing for the multiplexed display controller
// Notes on behaviour
// RULE1: Shift serial bit in on each serial rising edge.
// RULE2: Chip select high: serial clock is ignored.
// RULE3: Chip select rise latches all sixteen bits, executes.
// RULE4: Host sends bit 15 first, bit 0 last.
// RULE5: Bit 15 low writes data to address.
// RULE6: Host frames clock low, select, sixteen bits.
// RULE7: Odd bit counts keep last sixteen bits shifted.
// RULE8: Bit 15 high reads; dummy data is discarded.
// RULE9: Read loads register data into low byte.
// RULE10: Next frame returns address byte then data byte.
// RULE11: Driver clock is oscillator divided by four.
// RULE12: Driver stream length programmable up to 84 bits.
// RULE13: Driver data changes only on falling clock edges; the first bit of each stream changes as latch load falls.
// RULE14: Latch load high passes data, low holds.
// RULE15: Blanking polarity programmable; default high disables.
// RULE16: Shift next grid during slot; load at start.
// RULE17: Grid count register holds grids minus one.
// RULE18: Grid count writes above 0x2F store 0x2F.
// RULE19: Grid write blanks one full cycle, then fresh.
// RULE20: Brightness nibble sets on-time in sixteenths, max 15.
// RULE21: Each period opens with one disabled sixteenth.
// RULE22: Blanking serves brightness modulation and shutdown disable.
// RULE23: Polarity register bit 1 selects disable level.
// RULE24: Serial output is always actively driven.
// RULE25: Grid index steps to count then wraps.
// RULE26: Serial writes cross safely into oscillator domain.
`default_nettype none

package vfd_mux_pkg;

  localparam logic [6:0] ADDR_BLANK_POL   = 7'h01;
  localparam logic [6:0] ADDR_BRIGHTNESS  = 7'h02;
  localparam logic [6:0] ADDR_GRID_COUNT  = 7'h03;
  localparam logic [6:0] ADDR_SHIFT_LIMIT = 7'h0E;

  localparam int          FRAME_RW_BIT  = 15;
  localparam int          POL_BIT       = 1;
  localparam logic [7:0]  GRID_MAX      = 8'h2F;
  localparam logic [7:0]  SHIFT_MAX     = 8'h53;
  localparam logic [3:0]  DUTY_MAX      = 4'hE;
  localparam int          GRID_BITS     = 48;
  localparam int          ANODE_BITS    = 36;

  localparam logic [7:0]  POL_RESET     = 8'h00;
  localparam logic [7:0]  BRIGHT_RESET  = 8'h00;
  localparam logic [7:0]  GRID_RESET    = 8'h00;
  localparam logic [7:0]  SHIFT_RESET   = 8'h53;

  localparam int CLK_MHZ        = 100;
  localparam int OSC_MHZ        = 4;
  localparam int DRV_CLK_DIV    = 4;
  localparam int GRID_PERIOD_NS = 100000;
  localparam int SIXTEENTHS     = 16;
  localparam int GRID_PERIOD_CYC = GRID_PERIOD_NS * CLK_MHZ / 1000;
  localparam int SLOT_CYC       = GRID_PERIOD_CYC / SIXTEENTHS;
  localparam int DRV_HALF_CYC   = CLK_MHZ * DRV_CLK_DIV / OSC_MHZ / 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_SHIFT = 2'b10
  } drvState_t;

endpackage : vfd_mux_pkg

`default_nettype wire

//--- rtl/vfd_mux_serial_ctrl.sv
// Serial command port and multiplex engine of the display controller
`default_nettype none

module vfd_mux_serial_ctrl #(
  parameter int SLOT_CYCLES     = vfd_mux_pkg::SLOT_CYC,
  parameter int DRV_HALF_CYCLES = vfd_mux_pkg::DRV_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        serialClk,
  input  wire logic        chipSelN,
  input  wire logic        serialIn,
  input  wire logic        shutdown,
  input  wire logic [35:0] anodePattern,
  output logic             serialOut,
  output logic             driverShiftClock,
  output logic             driverDataOut,
  output logic             driverLatchLoad,
  output logic             driverBlanking
);

  logic [1:0]  rstPipe;
  logic        rstSyncN;

  logic [15:0] shiftReg;
  logic        loadSeen;
  logic        loadTog;
  logic [7:0]  readByte;

  logic [1:0]  csSync;
  logic        csPrev;
  logic [1:0]  seenSync;
  logic [1:0]  sdSync;
  logic [15:0] frameLatch;
  logic        execPend;

  logic [7:0]  blankPol;
  logic [7:0]  brightness;
  logic [7:0]  gridCount;
  logic [7:0]  shiftLimit;

  logic [15:0] slotCnt;
  logic [3:0]  phase;
  logic [5:0]  gridIdx;
  logic [6:0]  holdCnt;

  vfd_mux_pkg::drvState_t state;
  logic [6:0]  bitIdx;
  logic [15:0] halfCnt;

  logic        isRead;
  logic [6:0]  cmdAddr;
  logic [7:0]  cmdData;
  logic        doWrite;
  logic        doRead;
  logic        hitPol;
  logic        hitBrt;
  logic        hitGrid;
  logic        hitShift;
  logic [7:0]  gridValue;
  logic [7:0]  shiftValue;
  logic [7:0]  readMux;

  logic        slotEnd;
  logic        periodStart;
  logic [5:0]  nextGrid;

  logic [3:0]  dutyNib;
  logic [3:0]  onSix;
  logic        onWindow;
  logic        driveOn;
  logic        next_blank;

  logic        halfEnd;
  logic [6:0]  pickIdx;
  logic [6:0]  anodeOff;
  logic        isGridBit;
  logic        pickBit;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rstPipe <= 2'b00;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end

  assign rstSyncN = rstPipe[1];

  // Serial link domain. readByte and loadTog only change just after chip
  // select rises and then stand for the whole gap and the next frame, so
  // they are quasi-static words here; loadSeen returns the handshake.
  wire         loadNow   = loadTog != loadSeen;
  wire  [15:0] mergedReg = loadNow ? {shiftReg[15:8], readByte} : shiftReg;

  always_ff @(posedge serialClk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      shiftReg <= 16'h0000;
      loadSeen <= 1'b0;
    end
    else if (!chipSelN) // [RULE2]
    begin
      shiftReg <= {mergedReg[14:0], serialIn}; // [RULE1] [RULE7] [RULE10]
      loadSeen <= loadTog;
    end
  end

  // Changes on the falling edge so the host samples it on the rising one;
  // never floats, even with chip select high.
  always_ff @(negedge serialClk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      serialOut <= 1'b0;
    else
      serialOut <= shiftReg[15]; // [RULE24] [RULE10]
  end

  // Oscillator domain: chip select, handshake return and shutdown pin
  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      csSync   <= 2'b11;
      csPrev   <= 1'b1;
      seenSync <= 2'b00;
      sdSync   <= 2'b00;
    end
    else
    begin
      csSync   <= {csSync[0], chipSelN};
      csPrev   <= csSync[1];
      seenSync <= {seenSync[0], loadSeen};
      sdSync   <= {sdSync[0], shutdown};
    end
  end

  wire csRise      = csSync[1] & ~csPrev;
  wire pendingLoad = loadTog != seenSync[1];

  // A read answer never clocked out still counts as the low byte, so a
  // frame of zero bits replays it instead of the stale raw bits.
  wire [15:0] frameWord = pendingLoad ? {shiftReg[15:8], readByte} : shiftReg;

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      frameLatch <= 16'h0000;
      execPend   <= 1'b0;
    end
    else
    begin
      execPend <= csRise;
      if (csRise)
        frameLatch <= frameWord; // [RULE3] [RULE26]
    end
  end

  assign isRead   = frameLatch[vfd_mux_pkg::FRAME_RW_BIT];
  assign cmdAddr  = frameLatch[14:8];
  assign cmdData  = frameLatch[7:0];
  assign doWrite  = execPend & ~isRead; // [RULE5]
  assign doRead   = execPend & isRead; // [RULE8]

  assign hitPol   = cmdAddr == vfd_mux_pkg::ADDR_BLANK_POL;
  assign hitBrt   = cmdAddr == vfd_mux_pkg::ADDR_BRIGHTNESS;
  assign hitGrid  = cmdAddr == vfd_mux_pkg::ADDR_GRID_COUNT;
  assign hitShift = cmdAddr == vfd_mux_pkg::ADDR_SHIFT_LIMIT;

  assign gridValue  = (cmdData > vfd_mux_pkg::GRID_MAX) ?
                      vfd_mux_pkg::GRID_MAX : cmdData; // [RULE18]
  assign shiftValue = (cmdData > vfd_mux_pkg::SHIFT_MAX) ?
                      vfd_mux_pkg::SHIFT_MAX : cmdData;

  assign readMux = hitPol   ? blankPol   :
                   hitBrt   ? brightness :
                   hitGrid  ? gridCount  :
                   hitShift ? shiftLimit : 8'h00;

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      blankPol   <= vfd_mux_pkg::POL_RESET;
      brightness <= vfd_mux_pkg::BRIGHT_RESET;
      gridCount  <= vfd_mux_pkg::GRID_RESET;
      shiftLimit <= vfd_mux_pkg::SHIFT_RESET;
    end
    else if (doWrite)
    begin
      if (hitPol)
        blankPol <= cmdData; // [RULE23]
      if (hitBrt)
        brightness <= cmdData; // [RULE20]
      if (hitGrid)
        gridCount <= gridValue; // [RULE17] [RULE18]
      if (hitShift)
        shiftLimit <= shiftValue; // [RULE12]
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      readByte <= 8'h00;
      loadTog  <= 1'b0;
    end
    else if (doRead)
    begin
      readByte <= readMux; // [RULE9]
      loadTog  <= ~loadTog;
    end
  end

  // Multiplex timebase: sixteen slots per grid period
  assign slotEnd     = slotCnt == 16'(SLOT_CYCLES - 1);
  assign periodStart = (slotCnt == 16'h0000) && (phase == 4'h0);
  assign nextGrid    = (gridIdx >= gridCount[5:0]) ? 6'h00 : gridIdx + 6'h01;

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      slotCnt <= 16'h0000;
      phase   <= 4'h0;
    end
    else if (slotEnd)
    begin
      slotCnt <= 16'h0000;
      phase   <= phase + 4'h1;
    end
    else
      slotCnt <= slotCnt + 16'h0001;
  end

  // Hold counts the partial period in progress plus every grid of one
  // whole cycle, so the first unblanked period shows freshly sent data.
  wire [6:0] holdLoad = 7'(gridValue) + 7'h02;

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      gridIdx <= 6'h00;
      holdCnt <= 7'h00;
    end
    else
    begin
      if (periodStart)
        gridIdx <= nextGrid; // [RULE25]
      if (doWrite && hitGrid)
        holdCnt <= holdLoad; // [RULE19]
      else if (periodStart && holdCnt != 7'h00)
        holdCnt <= holdCnt - 7'h01; // [RULE19]
    end
  end

  // Brightness: first sixteenth always off, then value+1 sixteenths on, at most fifteen
  assign dutyNib    = (brightness[3:0] > vfd_mux_pkg::DUTY_MAX) ?
                      vfd_mux_pkg::DUTY_MAX : brightness[3:0];
  assign onSix      = dutyNib + 4'h1; // [RULE20]
  assign onWindow   = (phase != 4'h0) && (phase <= onSix); // [RULE21]
  assign driveOn    = onWindow && (holdCnt == 7'h00) && !sdSync[1]; // [RULE22]
  assign next_blank = blankPol[vfd_mux_pkg::POL_BIT] ? driveOn : ~driveOn; // [RULE15]

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      driverBlanking <= 1'b1;
    else
      driverBlanking <= next_blank; // [RULE15] [RULE23]
  end

  // Driver stream: grid selects on the low positions, anodes above them
  assign halfEnd   = halfCnt == 16'(DRV_HALF_CYCLES - 1);
  assign pickIdx   = (state == vfd_mux_pkg::ST_LOAD) ? shiftLimit[6:0] :
                     bitIdx - 7'h01;
  assign anodeOff  = pickIdx - 7'(vfd_mux_pkg::GRID_BITS);
  assign isGridBit = pickIdx < 7'(vfd_mux_pkg::GRID_BITS);
  assign pickBit   = isGridBit ? (pickIdx[5:0] == nextGrid) :
                     anodePattern[anodeOff[5:0]];

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state            <= vfd_mux_pkg::ST_IDLE;
      bitIdx           <= 7'h00;
      halfCnt          <= 16'h0000;
      driverShiftClock <= 1'b0;
      driverDataOut    <= 1'b0;
      driverLatchLoad  <= 1'b0;
    end
    else if (periodStart)
    begin
      state            <= vfd_mux_pkg::ST_LOAD;
      halfCnt          <= 16'h0000;
      driverShiftClock <= 1'b0;
      driverLatchLoad  <= 1'b1; // [RULE14] [RULE16]
    end
    else
    begin
      halfCnt <= halfEnd ? 16'h0000 : halfCnt + 16'h0001;
      case (state)
        vfd_mux_pkg::ST_LOAD:
        begin
          if (halfEnd)
          begin
            driverLatchLoad <= 1'b0; // [RULE14]
            bitIdx          <= shiftLimit[6:0];
            driverDataOut   <= pickBit; // [RULE12]
            state           <= vfd_mux_pkg::ST_SHIFT;
          end
        end
        vfd_mux_pkg::ST_SHIFT:
        begin
          if (halfEnd)
          begin
            driverShiftClock <= ~driverShiftClock; // [RULE11]
            if (driverShiftClock)
            begin
              if (bitIdx == 7'h00)
                state <= vfd_mux_pkg::ST_IDLE;
              else
              begin
                bitIdx        <= bitIdx - 7'h01;
                driverDataOut <= pickBit; // [RULE13] [RULE16]
              end
            end
          end
        end
        vfd_mux_pkg::ST_IDLE:
          driverShiftClock <= 1'b0;
        default:
          state <= vfd_mux_pkg::ST_IDLE;
      endcase
    end
  end

endmodule : vfd_mux_serial_ctrl

`default_nettype wire

//--- bench/vfd_mux_serial_ctrl_asserts.sv
// Port-level checks of the display controller
`default_nettype none
module vfd_mux_serial_ctrl_asserts #(
  parameter int SLOT_CYCLES     = 625,
  parameter int DRV_HALF_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic shutdown,
  input wire logic driverShiftClock,
  input wire logic driverDataOut,
  input wire logic driverLatchLoad,
  input wire logic driverBlanking
);
  logic [15:0] perCnt, loadLen, clkRun, shutCnt;
  logic [7:0]  riseCnt;
  logic        seen;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      {perCnt, loadLen, clkRun, shutCnt, riseCnt, seen} <= '0;
    else
    begin
      perCnt  <= $rose(driverLatchLoad) ? 16'h0000 : perCnt + 16'h0001;
      loadLen <= driverLatchLoad ? loadLen + 16'h0001 : 16'h0000;
      clkRun  <= $changed(driverShiftClock) ? 16'h0000 : clkRun + 16'h0001;
      shutCnt <= shutdown ? shutCnt + 16'h0001 : 16'h0000;
      riseCnt <= $rose(driverLatchLoad) ? 8'h00 : riseCnt + 8'($rose(driverShiftClock));
      seen    <= seen | $rose(driverLatchLoad);
    end
  end
  a_data_on_fall: assert property (@(posedge core_clk) disable iff (!rstn)
    $changed(driverDataOut) |-> $fell(driverShiftClock) || $fell(driverLatchLoad))
    else $error("driver data moved off a falling clock");
  a_load_width: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(driverLatchLoad) |-> loadLen == DRV_HALF_CYCLES)
    else $error("latch load pulse has wrong width");
  a_load_period: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(driverLatchLoad) && seen |-> perCnt == 16 * SLOT_CYCLES - 1)
    else $error("latch load spacing is not one grid period");
  a_clk_low_load: assert property (@(posedge core_clk) disable iff (!rstn)
    driverLatchLoad |-> !driverShiftClock)
    else $error("driver clock high during latch load");
  a_clk_half: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(driverShiftClock) |-> clkRun == DRV_HALF_CYCLES - 1)
    else $error("driver clock high time wrong");
  a_stream_len: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(driverLatchLoad) |-> riseCnt <= 8'h54)
    else $error("more than 84 driver bits in a period");
  a_setup_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(driverLatchLoad) |-> !driverShiftClock ##1 !driverShiftClock)
    else $error("driver clock rose too soon after load");
  a_shut_blank: assert property (@(posedge core_clk) disable iff (!rstn)
    shutCnt > 16'h0005 |-> $stable(driverBlanking))
    else $error("blanking moved during shutdown");
  c_load: cover property (@(posedge core_clk) $rose(driverLatchLoad));
  c_shut: cover property (@(posedge core_clk) $rose(shutdown));
  c_blank: cover property (@(posedge core_clk) $fell(driverBlanking));
endmodule : vfd_mux_serial_ctrl_asserts
bind vfd_mux_serial_ctrl vfd_mux_serial_ctrl_asserts #(
  .SLOT_CYCLES(SLOT_CYCLES),
  .DRV_HALF_CYCLES(DRV_HALF_CYCLES)
) i_vfd_mux_serial_ctrl_asserts (
  .core_clk(core_clk),
  .rstn(rstn),
  .shutdown(shutdown),
  .driverShiftClock(driverShiftClock),
  .driverDataOut(driverDataOut),
  .driverLatchLoad(driverLatchLoad),
  .driverBlanking(driverBlanking)
);
`default_nettype wire

//--- bench/vfd_host_model.sv
// Host side of the serial command port
`default_nettype none
module vfd_host_model (
  output logic      serialClk,
  output logic      chipSelN,
  output logic      serialIn,
  input  wire logic serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    serialClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end
  // Sends the low n bits of tx highest first; rx gathers serialOut at each rise
  task automatic xfer(input logic [31:0] tx, input int n, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    serialClk = 1'b0;
    #7 chipSelN = 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      #5 serialIn = tx[i];
      #1 serialClk = 1'b1;
      rx = {rx[14:0], serialOut};
      #6 if (i > 0) serialClk = 1'b0;
    end
    chipSelN = 1'b1;
    #3 serialClk = 1'b0;
    serialIn = ~serialIn;
    #80;
  endtask : xfer
  // Clock edges while deselected must leave the shift register alone
  task automatic noise;
    repeat (5)
    begin
      serialIn = ~serialIn;
      #6 serialClk = 1'b1;
      #6 serialClk = 1'b0;
    end
  endtask : noise
endmodule : vfd_host_model
`default_nettype wire

//--- bench/vfd_mux_serial_ctrl_tb_top.sv
// Self-checking bench for the display controller
`default_nettype none
module vfd_mux_serial_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOT = 40;
  logic core_clk, rstn, shutdown, serialClk, chipSelN, serialIn, serialOut;
  logic driverShiftClock, driverDataOut, driverLatchLoad, driverBlanking, enLevel;
  logic prevLoad, prevSclk;
  logic [35:0] anodePattern;
  logic [83:0] stream, lastStream;
  logic [7:0] d;
  logic [15:0] r;
  int bits, enCnt, lastBits, lastEn, nPer, badCount, nTests, i, g, seed;
  logic [7:0] gv [4] = '{8'h30, 8'hFF, 8'h2F, 8'h00};
  logic [7:0] bv [4] = '{8'hF0, 8'h07, 8'h0E, 8'h0F};
  vfd_mux_serial_ctrl #(.SLOT_CYCLES(SLOT), .DRV_HALF_CYCLES(1)) i_vfd_mux_serial_ctrl (
    .core_clk(core_clk), .rstn(rstn), .serialClk(serialClk), .chipSelN(chipSelN),
    .serialIn(serialIn), .shutdown(shutdown), .anodePattern(anodePattern),
    .serialOut(serialOut), .driverShiftClock(driverShiftClock),
    .driverDataOut(driverDataOut), .driverLatchLoad(driverLatchLoad),
    .driverBlanking(driverBlanking));
  vfd_host_model i_vfd_host_model (.serialClk(serialClk), .chipSelN(chipSelN),
    .serialIn(serialIn), .serialOut(serialOut));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Captures each driver stream and the enabled time of each grid period
  always @(posedge core_clk)
  begin
    prevLoad <= driverLatchLoad;
    prevSclk <= driverShiftClock;
    enCnt <= enCnt + int'(driverBlanking === enLevel);
    if (driverShiftClock && !prevSclk)
    begin
      stream <= {stream[82:0], driverDataOut};
      bits <= bits + 1;
    end
    if (driverLatchLoad && !prevLoad)
    begin
      lastStream <= stream;
      lastBits <= bits;
      lastEn <= enCnt;
      nPer <= nPer + 1;
      bits <= 0;
      enCnt <= 0;
      stream <= '0;
    end
  end
  task automatic completeRun;
    $display("Mismatches %0d, checks %0d", badCount, nTests);
    if (badCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : completeRun
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    nTests++;
    if (s !== e)
    begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic waitPer(input int n);
    int t0, k;
    t0 = nPer;
    for (k = 0; k < 2000 * n && nPer < t0 + n; k++) @(posedge core_clk);
    if (nPer < t0 + n)
    begin
      badCount++;
      completeRun();
    end
  endtask : waitPer
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    i_vfd_host_model.xfer({17'h00000, a, v}, 16, r);
  endtask : wr
  // Read frame, then a no-op frame that carries the answer out
  task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
    i_vfd_host_model.xfer({16'h0000, 1'b1, a, 8'h00}, 16, r);
    i_vfd_host_model.xfer(32'h00000000, 16, r);
    chk(36'(r[14:0]), 36'({a, e}));
  endtask : rdChk
  function automatic int gridOf(input logic [47:0] v);
    gridOf = -1;
    for (int k = 0; k < 48; k++) if (v[k] === 1'b1) gridOf = k;
  endfunction : gridOf
  // Brightness 14 and 15 both give fifteen sixteenths
  function automatic int onTime(input logic [7:0] v);
    onTime = ((v[3:0] > 4'hE) ? 15 : v[3:0] + 1) * SLOT;
  endfunction : onTime
  initial
  begin
    {rstn, shutdown, enLevel, anodePattern} = '0;
    seed = 32'h308F;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    anodePattern <= {4'hA, 32'($random(seed))};
    repeat (4) @(posedge core_clk);
    rdChk(7'h01, 8'h00);
    rdChk(7'h02, 8'h00);
    rdChk(7'h0E, 8'h53);
    wr(7'h55, 8'hA5);
    rdChk(7'h55, 8'h00);
    for (i = 0; i < 8; i++)
    begin
      d = i < 4 ? 8'($random(seed)) : gv[i - 4];
      wr(7'h02, d);
      rdChk(7'h02, d);
      wr(7'h03, d);
      rdChk(7'h03, d > 8'h2F ? 8'h2F : d);
    end
    i_vfd_host_model.xfer({8'hC3, 9'h002, 8'h07}, 24, r);
    rdChk(7'h02, 8'h07);
    i_vfd_host_model.xfer(32'h00000002, 8, r);
    i_vfd_host_model.noise();
    i_vfd_host_model.xfer(32'h00000009, 8, r);
    rdChk(7'h02, 8'h09);
    wr(7'h03, 8'h02);
    waitPer(5);
    chk(36'(lastBits), 36'h000000054);
    chk(lastStream[83:48], anodePattern);
    for (i = 0; i < 3; i++)
    begin
      g = gridOf(lastStream[47:0]);
      chk(36'($countones(lastStream[47:0])), 36'h1);
      waitPer(1);
      chk(36'(gridOf(lastStream[47:0])), 36'((g + 1) % 3));
    end
    for (i = 0; i < 6; i++)
    begin
      d = i < 4 ? bv[i] : 8'($random(seed));
      wr(7'h02, d);
      waitPer(2);
      chk(36'(lastEn), 36'(onTime(d)));
    end
    wr(7'h01, 8'h02);
    enLevel = 1'b1;
    waitPer(2);
    chk(36'(lastEn), 36'(onTime(d)));
    wr(7'h03, 8'h01);
    waitPer(2);
    chk(36'(lastEn), 36'h0);
    waitPer(3);
    chk(36'(lastEn), 36'(onTime(d)));
    @(posedge core_clk) shutdown <= 1'b1;
    waitPer(2);
    chk(36'(lastEn), 36'h0);
    @(posedge core_clk) shutdown <= 1'b0;
    waitPer(2);
    chk(36'(lastEn), 36'(onTime(d)));
    wr(7'h0E, 8'h0F);
    waitPer(2);
    chk(36'(lastBits), 36'h10);
    wr(7'h0E, 8'hFF);
    rdChk(7'h0E, 8'h53);
    completeRun();
  end
endmodule : vfd_mux_serial_ctrl_tb_top
`default_nettype wire
